// ==== logic/iopm_pkg.sv ====
package iopm_pkg;

	// ==========================================================
	// Command opcodes from the processor core
	typedef enum logic [4:0] {
		OP_PORT_ON        = 5'h00,
		OP_PORT_OFF       = 5'h01,
		OP_MODE_DATA      = 5'h02,
		OP_MODE_CLOCK     = 5'h03,
		OP_MODE_READY     = 5'h04,
		OP_DRIVE          = 5'h05,
		OP_DRIVE_LOW      = 5'h06,
		OP_PULL_UP        = 5'h07,
		OP_PULL_DOWN      = 5'h08,
		OP_PULL_NONE      = 5'h09,
		OP_PORT_CONTROL   = 5'h0a,
		OP_INV            = 5'h0b,
		OP_NO_INV         = 5'h0c,
		OP_SHIFT_COUNT    = 5'h0d,
		OP_PAD_DELAY      = 5'h0e,
		OP_SAMPLE_FALL    = 5'h0f,
		OP_SAMPLE_RISE    = 5'h10,
		OP_DIR_IN         = 5'h11,
		OP_DIR_OUT        = 5'h12
	} iopm_op_type;

	// ==========================================================
	// Argument codes carried by the port control command
	localparam logic [7:0] ROLE_MASTER_CODE     = 8'h01;
	localparam logic [7:0] ROLE_SLAVE_CODE      = 8'h02;
	localparam logic [7:0] READY_NONE_CODE      = 8'h03;
	localparam logic [7:0] READY_STROBED_CODE   = 8'h04;
	localparam logic [7:0] READY_HANDSHAKE_CODE = 8'h05;

	typedef enum logic [1:0] {
		PIN_DATA  = 2'h0,
		PIN_CLOCK = 2'h1,
		PIN_READY = 2'h2
	} iopm_pin_mode_type;

	typedef enum logic [1:0] {
		RDY_NONE      = 2'h0,
		RDY_STROBED   = 2'h1,
		RDY_HANDSHAKE = 2'h2
	} iopm_rdy_mode_type;

	// ==========================================================
	// Pad delay limits, in processor-clock cycles
	localparam int          PAD_DELAY_MAX     = 5;
	localparam logic [2:0]  PAD_DELAY_MAX_ARG = 3'h5;
	localparam logic [2:0]  PAD_DELAY_DEFAULT = 3'h0;

	typedef struct packed {
		iopm_op_type op;
		logic [7:0]  arg;
	} iopm_cmd_type;

	typedef struct packed {
		logic              on;
		iopm_pin_mode_type pin_mode;
		logic              drive_low;
		logic              pull_up;
		logic              pull_down;
		logic              master;
		iopm_rdy_mode_type rdy_mode;
		logic              inv;
		logic              sample_fall;
		logic              dir_out;
		logic [2:0]        pad_delay;
	} iopm_cfg_type;

	// Settings loaded on every turn-on
	localparam iopm_cfg_type CFG_DEFAULT = '{
		on: 1'b1, pin_mode: PIN_DATA, drive_low: 1'b0, pull_up: 1'b0,
		pull_down: 1'b0, master: 1'b1, rdy_mode: RDY_NONE, inv: 1'b0,
		sample_fall: 1'b0, dir_out: 1'b0, pad_delay: PAD_DELAY_DEFAULT};

	// Settings after chip reset: port off
	localparam iopm_cfg_type CFG_RESET = '{
		on: 1'b0, pin_mode: PIN_DATA, drive_low: 1'b0, pull_up: 1'b0,
		pull_down: 1'b0, master: 1'b1, rdy_mode: RDY_NONE, inv: 1'b0,
		sample_fall: 1'b0, dir_out: 1'b0, pad_delay: PAD_DELAY_DEFAULT};

endpackage

// ==== logic/iopm_port.sv ====
// Summary of operation
// - Turn-on loads defaults, also when already on
// - Off twice is harmless; use while off excepts
// - Data mode default; outputs set pin value
// - Clock mode drives port clock; 1-bit only
// - Ready mode drives ready source; 1-bit only
// - Drive mode drives pins, clears pulls
// - Drive-low: 0 pulls low, 1 floats
// - Pull-up selects drive-low or excepts
// - Pull-down selects drive-low or excepts
// - Pull none clears pulls, restores drive
// - Control command sets master or slave
// - Control command sets none/strobed/handshake ready
// - Inversion 1-bit only, inverts both directions
// - Shift count: nonzero, below width, aligned
// - Partial input lands in top bits
// - Partial output shifts count bits only
// - Pad delay 0 to 5 cycles
// - Shared pin uses highest-priority port delay
// - Sample on rising edge, falling after sample-fall command
// - Handshake output gated by ready-in, flags ready-out
// - Strobed master input: ready-out when not full
`timescale 1ns/1ps
module iopm_port
	import iopm_pkg::*;
#(
	parameter int PORT_WIDTH    = 1,
	parameter int XFER_WIDTH    = 32,
	parameter bit HAS_PULL_UP   = 1'b1,
	parameter bit HAS_PULL_DOWN = 1'b0
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  cmd_valid_i,
	input  wire iopm_cmd_type          cmd_i,
	output logic                       exception_o,
	input  wire logic                  out_valid_i,
	input  wire logic [XFER_WIDTH-1:0] out_data_i,
	output logic                       out_ready_o,
	output logic                       in_valid_o,
	output logic [XFER_WIDTH-1:0]      in_data_o,
	input  wire logic                  in_ready_i,
	input  wire logic                  port_clk_i,
	input  wire logic [PORT_WIDTH-1:0] pin_i,
	output logic [PORT_WIDTH-1:0]      pin_o,
	output logic [PORT_WIDTH-1:0]      pin_oe_o,
	output logic                       pull_up_o,
	output logic                       pull_down_o,
	input  wire logic                  ready_in_i,
	output logic                       ready_out_o,
	input  wire logic                  ready_src_i,
	output logic                       clk_src_o,
	input  wire logic                  prio_delay_valid_i,
	input  wire logic [2:0]            prio_delay_i
);

	localparam int CNT_W = $clog2(XFER_WIDTH + 1);
	localparam logic [CNT_W-1:0] PW_CNT = CNT_W'(PORT_WIDTH);
	localparam logic [CNT_W-1:0] XW_CNT = CNT_W'(XFER_WIDTH);

	// Parameter sanity at elaboration: arguments are 8 bits, words split evenly
	if (PORT_WIDTH < 1 || XFER_WIDTH < PORT_WIDTH || XFER_WIDTH > 255 ||
			(XFER_WIDTH % PORT_WIDTH) != 0 || (HAS_PULL_UP && HAS_PULL_DOWN)) begin : g_bad_param
		$error("iopm_port: unsupported parameter set");
	end

	// ==========================================================
	// Configuration and command decode
	iopm_cfg_type     cfg_q;
	logic [CNT_W-1:0] psc_q;
	logic             psc_set_q;
	logic             psc_used;
	logic             flush_q;
	logic             exc_q;

	localparam bit ONE_BIT = (PORT_WIDTH == 1);

	// True when a shift count argument may be accepted
	function automatic logic psc_ok(input logic [7:0] n);
		psc_ok = (n != 8'h00) && (32'(n) < XFER_WIDTH) && ((32'(n) % PORT_WIDTH) == 0);
	endfunction

	// Command process; rejected commands leave every setting untouched
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_q     <= CFG_RESET;
			psc_q     <= '0;
			psc_set_q <= 1'b0;
			flush_q   <= 1'b0;
			exc_q     <= 1'b0;
		end else begin
			flush_q <= 1'b0;
			exc_q   <= 1'b0; // Last refusal below wins
			if (psc_used)
				psc_set_q <= 1'b0;
			if (out_valid_i && !cfg_q.on)
				exc_q <= 1'b1;
			if (cmd_valid_i) begin
				if (cmd_i.op == OP_PORT_ON) begin
					cfg_q     <= CFG_DEFAULT;
					psc_set_q <= 1'b0;
					flush_q   <= 1'b1;
				end else if (cmd_i.op == OP_PORT_OFF) begin
					cfg_q.on <= 1'b0;
				end else if (!cfg_q.on) begin
					exc_q <= 1'b1;
				end else begin
					case (cmd_i.op)
						OP_MODE_DATA: cfg_q.pin_mode <= PIN_DATA;
						OP_MODE_CLOCK: begin
							if (ONE_BIT) cfg_q.pin_mode <= PIN_CLOCK;
							else exc_q <= 1'b1;
						end
						OP_MODE_READY: begin
							if (ONE_BIT) cfg_q.pin_mode <= PIN_READY;
							else exc_q <= 1'b1;
						end
						OP_DRIVE, OP_PULL_NONE: begin
							cfg_q.drive_low <= 1'b0;
							cfg_q.pull_up   <= 1'b0;
							cfg_q.pull_down <= 1'b0;
						end
						OP_DRIVE_LOW: begin
							cfg_q.drive_low <= 1'b1;
							cfg_q.pull_up   <= HAS_PULL_UP;
							cfg_q.pull_down <= HAS_PULL_DOWN;
						end
						OP_PULL_UP: begin
							if (HAS_PULL_UP) begin
								cfg_q.pull_up   <= 1'b1;
								cfg_q.drive_low <= 1'b1;
							end else exc_q <= 1'b1;
						end
						OP_PULL_DOWN: begin
							if (HAS_PULL_DOWN) begin
								cfg_q.pull_down <= 1'b1;
								cfg_q.drive_low <= 1'b1;
							end else exc_q <= 1'b1;
						end
						OP_PORT_CONTROL: begin
							case (cmd_i.arg)
								ROLE_MASTER_CODE: cfg_q.master <= 1'b1;
								ROLE_SLAVE_CODE: cfg_q.master <= 1'b0;
								READY_NONE_CODE: cfg_q.rdy_mode <= RDY_NONE;
								READY_STROBED_CODE: cfg_q.rdy_mode <= RDY_STROBED;
								READY_HANDSHAKE_CODE: cfg_q.rdy_mode <= RDY_HANDSHAKE;
								default: exc_q <= 1'b1;
							endcase
						end
						OP_INV: begin
							if (ONE_BIT) cfg_q.inv <= 1'b1;
							else exc_q <= 1'b1;
						end
						OP_NO_INV: cfg_q.inv <= 1'b0;
						OP_SHIFT_COUNT: begin
							if (psc_ok(cmd_i.arg)) begin
								psc_q     <= CNT_W'(cmd_i.arg);
								psc_set_q <= 1'b1; // Set wins over use
							end else exc_q <= 1'b1;
						end
						OP_PAD_DELAY: begin
							if (cmd_i.arg <= 8'(PAD_DELAY_MAX_ARG))
								cfg_q.pad_delay <= cmd_i.arg[2:0];
							else exc_q <= 1'b1;
						end
						OP_SAMPLE_FALL: cfg_q.sample_fall <= 1'b1;
						OP_SAMPLE_RISE: cfg_q.sample_fall <= 1'b0;
						OP_DIR_IN: cfg_q.dir_out <= 1'b0;
						OP_DIR_OUT: cfg_q.dir_out <= 1'b1;
						default: exc_q <= 1'b1;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Pin synchronisers: a change counts once stages two and three agree
	logic [2:0]            pclk_sync_q;
	logic                  pclk_lvl_q;
	logic [PORT_WIDTH-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
	logic [2:0]            rdy_sync_q;
	logic                  rdy_lvl_q;
	logic                  rise_ev, fall_ev;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pclk_sync_q <= '0;
			pclk_lvl_q  <= 1'b0;
			pin_s1_q    <= '0;
			pin_s2_q    <= '0;
			pin_s3_q    <= '0;
			pin_lvl_q   <= '0;
			rdy_sync_q  <= '0;
			rdy_lvl_q   <= 1'b0;
		end else begin
			pclk_sync_q <= {pclk_sync_q[1:0], port_clk_i};
			if (pclk_sync_q[1] == pclk_sync_q[2])
				pclk_lvl_q <= pclk_sync_q[2];
			pin_s1_q <= pin_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			for (int b = 0; b < PORT_WIDTH; b++) begin
				if (pin_s2_q[b] == pin_s3_q[b])
					pin_lvl_q[b] <= pin_s3_q[b];
			end
			rdy_sync_q <= {rdy_sync_q[1:0], ready_in_i};
			if (rdy_sync_q[1] == rdy_sync_q[2])
				rdy_lvl_q <= rdy_sync_q[2];
		end
	end

	// Edges of the port clock as seen after filtering
	assign rise_ev = (pclk_sync_q[1] == pclk_sync_q[2]) && pclk_sync_q[2] && !pclk_lvl_q;
	assign fall_ev = (pclk_sync_q[1] == pclk_sync_q[2]) && !pclk_sync_q[2] && pclk_lvl_q;

	// ==========================================================
	// Input pad delay line
	logic [PAD_DELAY_MAX:1][PORT_WIDTH-1:0] dly_q;
	logic [2:0]                             dly_sel;
	logic [PORT_WIDTH-1:0]                  smp;

	genvar k;
	generate
		for (k = 1; k <= PAD_DELAY_MAX; k++) begin : g_dly
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) dly_q[k] <= '0;
				else dly_q[k] <= (k == 1) ? pin_lvl_q : dly_q[(k > 1) ? k-1 : 1];
			end
		end
	endgenerate

	// A higher-priority port on the same pin overrides our delay
	assign dly_sel = prio_delay_valid_i ? prio_delay_i : cfg_q.pad_delay;
	assign smp = ((dly_sel == 3'h0) ? pin_lvl_q :
			(dly_sel > PAD_DELAY_MAX_ARG) ? dly_q[PAD_DELAY_MAX] : dly_q[dly_sel]) ^
			{PORT_WIDTH{cfg_q.inv}};

	// ==========================================================
	// Input path: shift-in and two-entry buffer toward the core
	logic                  smp_ev;
	logic                  strobe_req_q;
	logic                  rdy_seen_q;
	logic [XFER_WIDTH-1:0] in_sh_q;
	logic [CNT_W-1:0]      in_cnt_q;
	logic [CNT_W-1:0]      xfer_len;
	logic                  take_in, push, pop;
	logic [XFER_WIDTH-1:0] push_data;
	logic                  head_v_q, spare_v_q;
	logic [XFER_WIDTH-1:0] spare_q;

	assign smp_ev   = cfg_q.sample_fall ? fall_ev : rise_ev;
	assign xfer_len = psc_set_q ? psc_q : XW_CNT;

	// Sampling decision per ready mode; strobed slaves follow ready-in
	always_comb begin
		take_in = 1'b0;
		if (cfg_q.on && !cfg_q.dir_out && smp_ev) begin
			case (cfg_q.rdy_mode)
				RDY_NONE: take_in = 1'b1;
				RDY_STROBED: take_in = cfg_q.master ? strobe_req_q : rdy_lvl_q;
				RDY_HANDSHAKE: take_in = strobe_req_q && rdy_lvl_q;
				default: take_in = 1'b0;
			endcase
		end
	end

	// New bits enter at the top, so a short word ends up in the MSBs
	assign push_data = {smp, in_sh_q[XFER_WIDTH-1:PORT_WIDTH]};
	assign push      = take_in && (CNT_W'(in_cnt_q + PW_CNT) >= xfer_len);
	assign pop       = head_v_q && in_ready_i;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_sh_q  <= '0;
			in_cnt_q <= '0;
		end else if (flush_q) begin
			in_cnt_q <= '0;
		end else if (take_in) begin
			in_sh_q  <= push_data;
			in_cnt_q <= push ? '0 : CNT_W'(in_cnt_q + PW_CNT);
		end
	end

	// Two-entry buffer; a stalled core loses no word until both fill
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			head_v_q  <= 1'b0;
			spare_v_q <= 1'b0;
			in_data_o <= '0;
			spare_q   <= '0;
		end else if (flush_q) begin
			head_v_q  <= 1'b0;
			spare_v_q <= 1'b0;
		end else begin
			if (!head_v_q || pop) begin
				if (spare_v_q) begin
					in_data_o <= spare_q;
					head_v_q  <= 1'b1;
					spare_v_q <= push;
					spare_q   <= push_data;
				end else begin
					head_v_q  <= push;
					in_data_o <= push ? push_data : in_data_o;
				end
			end else if (push && !spare_v_q) begin
				spare_v_q <= 1'b1;
				spare_q   <= push_data;
			end
		end
	end
	assign in_valid_o = head_v_q;

	// ==========================================================
	// Output path: staging word and shift-out on falling edges
	logic                  stage_v_q;
	logic [XFER_WIDTH-1:0] stage_q;
	logic [XFER_WIDTH-1:0] out_sh_q;
	logic [CNT_W-1:0]      out_left_q;
	logic                  may_out, drive_ev, load_ev, accept;
	logic [PORT_WIDTH-1:0] out_val_q;

	// Handshake and strobed slave wait for the last sampled ready-in
	always_comb begin
		case (cfg_q.rdy_mode)
			RDY_NONE: may_out = 1'b1;
			RDY_STROBED: may_out = cfg_q.master || rdy_seen_q;
			RDY_HANDSHAKE: may_out = rdy_seen_q;
			default: may_out = 1'b0;
		endcase
	end

	assign load_ev  = (out_left_q == '0) && stage_v_q;
	assign drive_ev = cfg_q.on && cfg_q.dir_out && fall_ev && may_out &&
			((out_left_q != '0) || stage_v_q);
	assign accept   = out_valid_i && out_ready_o;
	assign psc_used = (drive_ev && load_ev) || push;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage_v_q   <= 1'b0;
			stage_q     <= '0;
			out_sh_q    <= '0;
			out_left_q  <= '0;
			out_val_q   <= '0;
			out_ready_o <= 1'b0;
		end else if (flush_q) begin
			stage_v_q   <= 1'b0;
			out_left_q  <= '0;
			out_ready_o <= 1'b1;
		end else begin
			if (drive_ev && load_ev) begin
				out_val_q  <= stage_q[PORT_WIDTH-1:0];
				out_sh_q   <= stage_q >> PORT_WIDTH;
				out_left_q <= CNT_W'(xfer_len - PW_CNT);
			end else if (drive_ev) begin
				out_val_q  <= out_sh_q[PORT_WIDTH-1:0];
				out_sh_q   <= out_sh_q >> PORT_WIDTH;
				out_left_q <= CNT_W'(out_left_q - PW_CNT);
			end
			if (accept) begin
				stage_v_q <= 1'b1;
				stage_q   <= out_data_i;
			end else if (drive_ev && load_ev) begin
				stage_v_q <= 1'b0;
			end
			out_ready_o <= cfg_q.on && !(accept || (stage_v_q && !(drive_ev && load_ev)));
		end
	end

	// ==========================================================
	// Ready handshake signals, updated on port clock edges
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdy_seen_q   <= 1'b0;
			strobe_req_q <= 1'b0;
			ready_out_o  <= 1'b0;
		end else begin
			if (smp_ev)
				rdy_seen_q <= rdy_lvl_q;
			if (!cfg_q.on || cfg_q.rdy_mode == RDY_NONE) begin
				ready_out_o  <= 1'b0;
				strobe_req_q <= 1'b0;
			end else if (fall_ev) begin
				if (cfg_q.dir_out) begin
					ready_out_o <= drive_ev;
				end else begin
					strobe_req_q <= !spare_v_q;
					ready_out_o  <= !spare_v_q;
				end
			end else if (take_in) begin
				strobe_req_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin drivers, pulls and clock-source view
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_o       <= '0;
			pin_oe_o    <= '0;
			pull_up_o   <= 1'b0;
			pull_down_o <= 1'b0;
			clk_src_o   <= 1'b0;
			exception_o <= 1'b0;
		end else begin
			exception_o <= exc_q;
			pull_up_o   <= cfg_q.on && cfg_q.pull_up;
			pull_down_o <= cfg_q.on && cfg_q.pull_down;
			clk_src_o   <= smp[0];
			if (!cfg_q.on) begin
				pin_oe_o <= '0;
			end else if (cfg_q.pin_mode == PIN_CLOCK) begin
				pin_o    <= {PORT_WIDTH{pclk_lvl_q ^ cfg_q.inv}};
				pin_oe_o <= '1;
			end else if (cfg_q.pin_mode == PIN_READY) begin
				pin_o    <= {PORT_WIDTH{ready_src_i ^ cfg_q.inv}};
				pin_oe_o <= '1;
			end else if (!cfg_q.dir_out) begin
				pin_oe_o <= '0;
			end else if (cfg_q.drive_low) begin
				pin_o    <= '0;
				pin_oe_o <= ~(out_val_q ^ {PORT_WIDTH{cfg_q.inv}});
			end else begin
				pin_o    <= out_val_q ^ {PORT_WIDTH{cfg_q.inv}};
				pin_oe_o <= '1;
			end
		end
	end

endmodule

// ==== bench/iopm_port_props.sv ====
`timescale 1ns/1ps
module iopm_port_props
	import iopm_pkg::*;
#(
	parameter int PORT_WIDTH    = 1,
	parameter int XFER_WIDTH    = 32,
	parameter bit HAS_PULL_UP   = 1'b1,
	parameter bit HAS_PULL_DOWN = 1'b0
) (
	input wire logic         clk_i,
	input wire logic         reset_n_i,
	input wire logic         cmd_valid_i,
	input wire iopm_cmd_type cmd_i,
	input wire logic         exception_o,
	input wire logic         pull_up_o,
	input wire logic         pull_down_o
);
	logic on_q;
	logic go;
	// ====================================================
	// On/off shadow; ON and OFF themselves are never refused
	assign go = cmd_valid_i && on_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			on_q <= 1'b0;
		else if (cmd_valid_i && cmd_i.op == OP_PORT_ON)
			on_q <= 1'b1;
		else if (cmd_valid_i && cmd_i.op == OP_PORT_OFF)
			on_q <= 1'b0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ====================================================
	// Command outcomes, two cycles after the taking edge
	chk_exc_single: assert property (exception_o |=> !exception_o)
		else $error("exception held over one cycle");
	chk_use_off: assert property (cmd_valid_i && !on_q &&
		!(cmd_i.op inside {OP_PORT_ON, OP_PORT_OFF}) |-> ##2 exception_o) else $error("use off");
	chk_off_twice: assert property (cmd_valid_i && !on_q && cmd_i.op == OP_PORT_OFF
		|-> ##2 !exception_o) else $error("second off excepted");
	chk_on_defaults: assert property (cmd_valid_i && cmd_i.op == OP_PORT_ON ##1 !cmd_valid_i
		|-> ##1 !exception_o && !pull_up_o && !pull_down_o) else $error("on defaults");
	chk_pull_up: assert property (go && cmd_i.op == OP_PULL_UP ##1 !cmd_valid_i
		|-> ##1 (HAS_PULL_UP ? pull_up_o : exception_o)) else $error("pull-up");
	chk_pull_down: assert property (go && cmd_i.op == OP_PULL_DOWN ##1 !cmd_valid_i
		|-> ##1 (HAS_PULL_DOWN ? pull_down_o : exception_o)) else $error("pull-down");
	chk_pulls_off: assert property (go && cmd_i.op inside {OP_DRIVE, OP_PULL_NONE}
		##1 !cmd_valid_i |-> ##1 !pull_up_o && !pull_down_o) else $error("pulls left on");
	chk_drive_low: assert property (go && cmd_i.op == OP_DRIVE_LOW ##1 !cmd_valid_i
		|-> ##1 (pull_up_o || pull_down_o)) else $error("drive-low without pull");
	chk_pad_range: assert property (go && cmd_i.op == OP_PAD_DELAY &&
		cmd_i.arg > 8'h05 |-> ##2 exception_o) else $error("pad delay over range");
	chk_shift_bad: assert property (go && cmd_i.op == OP_SHIFT_COUNT && (cmd_i.arg == 8'h00
		|| cmd_i.arg >= XFER_WIDTH) |-> ##2 exception_o) else $error("shift count taken");
	chk_one_bit: assert property (go && cmd_i.op inside {OP_MODE_CLOCK, OP_MODE_READY, OP_INV}
		|-> ##2 (exception_o != (PORT_WIDTH == 1))) else $error("one-bit mode");
endmodule
bind iopm_port iopm_port_props #(
	.PORT_WIDTH(PORT_WIDTH),
	.XFER_WIDTH(XFER_WIDTH),
	.HAS_PULL_UP(HAS_PULL_UP),
	.HAS_PULL_DOWN(HAS_PULL_DOWN)
) iopm_port_props_inst (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.cmd_valid_i(cmd_valid_i),
	.cmd_i(cmd_i),
	.exception_o(exception_o),
	.pull_up_o(pull_up_o),
	.pull_down_o(pull_down_o)
);

// ==== bench/iopm_pin_model.sv ====
`timescale 1ns/1ps
module iopm_pin_model (
	input  wire logic  clk_i,
	input  wire logic  stall_i,
	input  wire logic  ext_en_i,
	input  wire logic  ext_val_i,
	input  wire logic  pin_o,
	input  wire logic  pin_oe_o,
	input  wire logic  pull_up_o,
	input  wire logic  pull_down_o,
	input  wire logic  ready_out_o,
	output logic       port_clk_o,
	output logic       ready_in_o,
	output logic       level_o,
	output logic [7:0] cap_q,
	output int         n_cap
);
	int   div_q  = 0;
	logic last_q = 1'b0;
	initial port_clk_o = 1'b0;
	initial ready_in_o = 1'b1;
	initial n_cap = 0;
	// ====================================================
	// Port clock: 8 cycles a phase, above the synchroniser's need
	always @(posedge clk_i) begin
		div_q <= (div_q == 7) ? 0 : div_q + 1;
		if (div_q == 7)
			port_clk_o <= ~port_clk_o;
	end
	// Peer ready-in moves only on falls, so each rise sees it settled
	always @(negedge port_clk_o) ready_in_o <= ~stall_i;
	// Wire level; a floating line toggles so no stale value looks valid
	always_comb begin
		if (pin_oe_o)
			level_o = pin_o;
		else if (ext_en_i)
			level_o = ext_val_i;
		else if (pull_up_o)
			level_o = 1'b1;
		else if (pull_down_o)
			level_o = 1'b0;
		else
			level_o = ~last_q;
	end
	always @(posedge clk_i) last_q <= level_o;
	// One slice per rise that follows a fall flagged by ready-out
	always @(posedge port_clk_o) begin
		if (ready_out_o === 1'b1) begin
			cap_q <= {level_o, cap_q[7:1]};
			n_cap <= n_cap + 1;
		end
	end
endmodule

// ==== bench/iopm_port_tb.sv ====
`timescale 1ns/1ps
module iopm_port_tb
	import iopm_pkg::*;
;
	logic clk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0, out_valid_i = 1'b0;
	logic in_ready_i = 1'b0, ready_src_i = 1'b0, stall = 1'b0, ext_en = 1'b0, ext_val = 1'b0;
	iopm_cmd_type cmd_i = '0;
	logic [7:0] out_data_i = 8'h00, in_data_o, cap, w, d;
	logic exception_o, out_ready_o, in_valid_o, port_clk, level, pin_o, pin_oe_o;
	logic pull_up_o, pull_down_o, ready_in, ready_out_o, c_clk;
	logic prio_v = 1'b0;
	logic [2:0] prio_d = 3'h0;
	int n_errors = 0, n_compared = 0, n_cap, c0, c1;
	iopm_op_type ops[7] = '{OP_MODE_CLOCK, OP_MODE_READY, OP_MODE_DATA, OP_INV, OP_NO_INV,
		OP_SAMPLE_FALL, OP_SAMPLE_RISE};
	logic [7:0] codes[6] = '{ROLE_MASTER_CODE, ROLE_SLAVE_CODE, READY_NONE_CODE,
		READY_STROBED_CODE, READY_HANDSHAKE_CODE, 8'h06};
	always #5 clk_i = ~clk_i;
	// Far-side ready source toggles at random to exercise ready mode
	always @(negedge clk_i) ready_src_i <= 1'($urandom_range(1));
	iopm_port #(.XFER_WIDTH(8)) iopm_port_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .exception_o(exception_o),
		.out_valid_i(out_valid_i), .out_data_i(out_data_i), .out_ready_o(out_ready_o),
		.in_valid_o(in_valid_o), .in_data_o(in_data_o), .in_ready_i(in_ready_i),
		.port_clk_i(port_clk), .pin_i(level), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .ready_in_i(ready_in),
		.ready_out_o(ready_out_o), .ready_src_i(ready_src_i), .clk_src_o(c_clk),
		.prio_delay_valid_i(prio_v), .prio_delay_i(prio_d));
	iopm_pin_model iopm_pin_model_inst (.clk_i(clk_i), .stall_i(stall), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
		.pull_down_o(pull_down_o), .ready_out_o(ready_out_o), .port_clk_o(port_clk),
		.ready_in_o(ready_in), .level_o(level), .cap_q(cap), .n_cap(n_cap));
	// ====================================================
	// Shared helpers
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask
	// Command strobe for one cycle; refusal shows two edges after taking
	task automatic send(input iopm_op_type op, input logic [7:0] arg, input logic exc);
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_i = '{op: op, arg: arg};
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		@(negedge clk_i);
		check("exception", 32'(exc), 32'(exception_o));
	endtask
	task automatic ports(input int n);
		repeat (n) @(posedge port_clk);
		@(negedge clk_i);
	endtask
	// Word held until an edge sees ready high; ready checked where settled
	task automatic put(input logic [7:0] v);
		int k;
		k = 0;
		@(negedge clk_i);
		out_valid_i = 1'b1;
		out_data_i = v;
		while (out_ready_o !== 1'b1 && k < 400) begin
			@(negedge clk_i);
			k++;
		end
		@(negedge clk_i);
		out_valid_i = 1'b0;
	endtask
	task automatic get(output logic [7:0] v);
		int k;
		k = 0;
		@(negedge clk_i);
		while (in_valid_o !== 1'b1 && k < 400) begin
			@(negedge clk_i);
			k++;
		end
		v = in_data_o;
		in_ready_i = 1'b1;
		@(negedge clk_i);
		in_ready_i = 1'b0;
	endtask
	// Stale words may hold bits from before a setting; the third is clean
	task automatic fresh(input logic [7:0] exp);
		ports(20);
		repeat (3) get(d);
		check("in_data", 32'(exp), 32'(d));
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	// ====================================================
	// Main sequence
	initial begin
		void'($urandom(3));
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		check("pin_oe", 0, 32'(pin_oe_o));
		send(OP_PULL_UP, 8'h00, 1'b1);
		send(OP_PORT_OFF, 8'h00, 1'b0);
		send(OP_PORT_ON, 8'h00, 1'b0);
		send(OP_PULL_UP, 8'h00, 1'b0);
		check("pull_up", 1, 32'(pull_up_o));
		send(OP_PORT_ON, 8'h00, 1'b0);
		check("pull_up", 0, 32'(pull_up_o));
		send(OP_DRIVE_LOW, 8'h00, 1'b0);
		check("pull_up", 1, 32'(pull_up_o));
		send(OP_DRIVE, 8'h00, 1'b0);
		check("pull_up", 0, 32'(pull_up_o));
		send(OP_PULL_DOWN, 8'h00, 1'b1);
		check("pull_down", 0, 32'(pull_down_o));
		send(OP_PULL_UP, 8'h00, 1'b0);
		send(OP_PULL_NONE, 8'h00, 1'b0);
		check("pull_up", 0, 32'(pull_up_o));
		foreach (codes[i]) send(OP_PORT_CONTROL, codes[i], i == 5);
		send(OP_MODE_CLOCK, 8'h00, 1'b0);
		check("clock pin_oe", 1, 32'(pin_oe_o));
		foreach (ops[i]) send(ops[i], 8'h00, 1'b0);
		send(OP_PAD_DELAY, 8'h05, 1'b0);
		send(OP_PAD_DELAY, 8'h06, 1'b1);
		repeat (10) begin
			w = 8'($urandom_range(7));
			send(OP_PAD_DELAY, w, w > 8'h05);
			w = 8'($urandom_range(11));
			send(OP_SHIFT_COUNT, w, w == 8'h00 || w >= 8'h08);
		end
		// Handshake output, with the peer stalling mid-word
		send(OP_PORT_ON, 8'h00, 1'b0);
		send(OP_DIR_OUT, 8'h00, 1'b0);
		send(OP_PORT_CONTROL, READY_HANDSHAKE_CODE, 1'b0);
		w = 8'($urandom);
		c0 = n_cap;
		put(w);
		ports(3);
		stall = 1'b1;
		ports(2);
		c1 = n_cap;
		ports(4);
		check("stalled count", c1, n_cap);
		stall = 1'b0;
		ports(12);
		check("out count", c0 + 8, n_cap);
		check("out word", 32'(w), 32'(cap));
		send(OP_SHIFT_COUNT, 8'h04, 1'b0);
		w = 8'($urandom);
		put(w);
		ports(12);
		check("part count", c0 + 12, n_cap);
		check("part bits", 32'(w[3:0]), 32'(cap[7:4]));
		// Input: pull-up, inversion, then strobed master flow control
		send(OP_PORT_ON, 8'h00, 1'b0);
		send(OP_PULL_UP, 8'h00, 1'b0);
		fresh(8'hff);
		send(OP_PULL_NONE, 8'h00, 1'b0);
		ext_en = 1'b1;
		send(OP_INV, 8'h00, 1'b0);
		fresh(8'hff);
		check("clk_src", 1, 32'(c_clk));
		send(OP_NO_INV, 8'h00, 1'b0);
		fresh(8'h00);
		check("clk_src", 0, 32'(c_clk));
		// A higher-priority port's pad delay holds the sampled bit back
		prio_v = 1'b1;
		prio_d = 3'h5;
		ext_val = 1'b1;
		repeat (9) @(negedge clk_i);
		check("clk_src early", 0, 32'(c_clk));
		@(negedge clk_i);
		check("clk_src late", 1, 32'(c_clk));
		send(OP_PORT_CONTROL, READY_STROBED_CODE, 1'b0);
		ports(30);
		check("ready_out full", 0, 32'(ready_out_o));
		get(d);
		ports(2);
		check("ready_out room", 1, 32'(ready_out_o));
		complete_run();
	end
endmodule
